// ### logic/cpw_map.svh
// Function
// RL1: seven outputs per 350us carrier period from a coupled up/down counter pair; the code uses one up/down counter
// RL2: normal phases are modulated PWM with no dead time against counter phases
// RL3: all normal phases share one waveform, all counter phases share another
// RL4: seventh output inverts every half carrier period, duty independent
// RL5: software duty goes to a buffer, reaches compare only at period boundary
// RL6: comparator above reference cuts PWM and puts every output in high impedance
// RL7: comparator back below reference releases high impedance, PWM resumes
// RL8: two comparator channels can cut; a zero-reference channel never cuts
// RL9: direct comparator path adds no event-link delay and gives high impedance only
// RL10: event-link path forces high impedance, high or low, with added latency
// RL11: counters run on the peripheral clock, setting period and duty time base
// RL12: three channels of normal and counter pin, plus the toggle pin
// RL13: outputs active low, inactive high after init and before counting
// RL14: buffer to compare transfer happens on counter underflow
// RL15: cutoff entered on comparator rising edge, released on falling edge
// RL16: comparator inputs synchronised before edge detection; enable applied quickly
`ifndef CPW_MAP_SVH
`define CPW_MAP_SVH
`define CPW_PERIOD_NS     350000
`define CPW_CLK_PERIOD_NS 4
`define CPW_PERIOD_CYC    (`CPW_PERIOD_NS / `CPW_CLK_PERIOD_NS)
`define CPW_CNT_W         16
`define CPW_EVL_LAT       2
`define CPW_CMP_CH        2
`define CPW_OUT_INACTIVE  1'b1
`endif

// ### logic/cpw_pkg.sv
package cpw_pkg;
  // level forced on the pins by the event-link cutoff path
  typedef enum logic [1:0] {CPW_FORCE_HIZ, CPW_FORCE_HIGH, CPW_FORCE_LOW} cpw_force_e;
  // counter run state
  typedef enum logic {CPW_IDLE, CPW_RUN} cpw_state_e;
endpackage

// ### logic/cpw_edge_sync.sv
`timescale 1ns/100ps
// two-flop synchroniser plus a third stage for edge detection
module cpw_edge_sync (
  // clock and reset
  input  wire logic clk,
  input  wire logic rstn,
  // asynchronous level in
  input  wire logic async_in,
  // synchronised level and edges
  output logic      level,
  output logic      rise,
  output logic      fall
);
  logic s1_reg, s2_reg, s3_reg;
  logic s1_next, s2_next, s3_next;

  // first stage feeds only the second, so no logic sees a metastable value
  always_comb begin
    s1_next = async_in;
    s2_next = s1_reg;
    s3_next = s2_reg;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
    end else begin
      s1_reg <= s1_next;
      s2_reg <= s2_next;
      s3_reg <= s3_next;
    end
  end

  // edges taken from stable stages only
  assign level = s2_reg;
  assign rise  = s2_reg & ~s3_reg; // see RL16
  assign fall  = ~s2_reg & s3_reg;
endmodule

// ### logic/cpw_top.sv
`timescale 1ns/100ps
`include "cpw_map.svh"
module cpw_top import cpw_pkg::*; #(
  parameter int PERIOD_CYC = `CPW_PERIOD_CYC,
  parameter int CW         = `CPW_CNT_W,
  parameter int EVL_LAT    = `CPW_EVL_LAT
) (
  // clock and reset
  input  wire logic                    clk,
  input  wire logic                    rstn,
  // counting control and duty buffer
  input  wire logic                    run_enable,
  input  wire logic                    duty_wr,
  input  wire logic [CW-1:0]           duty_value,
  // overcurrent comparators, asynchronous
  input  wire logic [`CPW_CMP_CH-1:0]  comparator_hiz_request,
  input  wire logic [`CPW_CMP_CH-1:0]  cmp_channel_armed,
  // event-link cutoff path
  input  wire logic                    event_link_controller_req,
  input  wire cpw_force_e              event_link_controller_mode,
  // channel 1 pins
  output logic                         phase1_normal_out,
  output logic                         phase1_normal_oe,
  output logic                         phase1_counter_out,
  output logic                         phase1_counter_oe,
  // channel 2 pins
  output logic                         phase2_normal_out,
  output logic                         phase2_normal_oe,
  output logic                         phase2_counter_out,
  output logic                         phase2_counter_oe,
  // channel 3 pins
  output logic                         phase3_normal_out,
  output logic                         phase3_normal_oe,
  output logic                         phase3_counter_out,
  output logic                         phase3_counter_oe,
  // half-period toggle pin
  output logic                         half_period_toggle_out,
  output logic                         half_period_toggle_oe,
  // status
  output logic                         cutoff_active
);
  localparam int HALF = PERIOD_CYC / 2;
  localparam logic [CW-1:0] HALF_M1 = CW'(HALF - 1);

  cpw_state_e               state_reg, state_next;
  logic [CW-1:0]            cnt_reg, cnt_next;
  logic                     up_reg, up_next;
  logic [CW-1:0]            buf_reg, buf_next;
  logic [CW-1:0]            cmp_reg, cmp_next;
  logic                     nrm_reg, nrm_next;
  logic                     ctr_reg, ctr_next;
  logic                     tog_reg, tog_next;
  logic                     oe_reg, oe_next;
  logic                     cut_out_reg, cut_out_next;
  logic [`CPW_CMP_CH-1:0]   cut_reg, cut_next;
  logic [EVL_LAT-1:0]       evl_reg, evl_next;
  logic                     half_evt, boundary, evl_active, force_lvl;
  logic [`CPW_CMP_CH-1:0]   cmp_rise, cmp_fall;

  // one synchroniser per comparator channel
  genvar g;
  generate
    for (g = 0; g < `CPW_CMP_CH; g++) begin : g_sync
      cpw_edge_sync u_sync (
        .clk      (clk),
        .rstn     (rstn),
        .async_in (comparator_hiz_request[g]),
        .level    (),
        .rise     (cmp_rise[g]),
        .fall     (cmp_fall[g])
      );
    end
  endgenerate

  // peak and valley of the triangle carrier
  assign half_evt = (state_reg == CPW_RUN) &&
                    ((up_reg && cnt_reg == HALF_M1) || (!up_reg && cnt_reg == CW'(1)));
  assign boundary = (state_reg == CPW_RUN) && !up_reg && cnt_reg == CW'(1); // see RL14
  assign evl_active = evl_reg[EVL_LAT-1];
  assign force_lvl  = evl_active && event_link_controller_mode != CPW_FORCE_HIZ;

  // carrier counter; each half is HALF clocks so a period is PERIOD_CYC
  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    up_next    = up_reg;
    case (state_reg)
      CPW_IDLE: begin
        cnt_next = '0;
        up_next  = 1'b1;
        if (run_enable) begin
          state_next = CPW_RUN;
        end
      end
      CPW_RUN: begin
        if (!run_enable) begin
          state_next = CPW_IDLE;
          cnt_next   = '0;
          up_next    = 1'b1;
        end else begin
          cnt_next = up_reg ? cnt_reg + CW'(1) : cnt_reg - CW'(1); // see RL1, RL11
          if (half_evt) begin
            up_next = ~up_reg;
          end
        end
      end
      default: state_next = CPW_IDLE;
    endcase
  end

  // duty buffer; compare only loads at the valley so a period never splits
  always_comb begin
    buf_next = duty_wr ? duty_value : buf_reg; // see RL5
    cmp_next = boundary ? buf_reg : cmp_reg;   // see RL5, RL14
  end

  // pin levels; one normal and one counter waveform fan out to all three channels
  always_comb begin
    if (state_next != CPW_RUN) begin
      nrm_next = `CPW_OUT_INACTIVE; // see RL13
      ctr_next = `CPW_OUT_INACTIVE;
      tog_next = `CPW_OUT_INACTIVE;
    end else begin
      nrm_next = ~(cnt_next < cmp_next); // see RL2, RL13
      ctr_next = ~nrm_next;              // see RL2
      tog_next = half_evt ? ~tog_reg : tog_reg; // see RL4
    end
    if (force_lvl) begin
      nrm_next = (event_link_controller_mode == CPW_FORCE_HIGH); // see RL10
      ctr_next = nrm_next;
      tog_next = nrm_next;
    end
  end

  // cutoff: direct comparator path has only the synchroniser in front
  always_comb begin
    for (int c = 0; c < `CPW_CMP_CH; c++) begin
      if (!cmp_channel_armed[c]) begin
        cut_next[c] = 1'b0;              // see RL8
      end else if (cmp_rise[c]) begin
        cut_next[c] = 1'b1;              // see RL6, RL15
      end else if (cmp_fall[c]) begin
        cut_next[c] = 1'b0;              // see RL7, RL15
      end else begin
        cut_next[c] = cut_reg[c];
      end
    end
    evl_next     = {evl_reg[EVL_LAT-2:0], event_link_controller_req}; // see RL10
    // enable computed from next values so pins float one edge after the edge is seen
    cut_out_next = (|cut_next) ||
                   (evl_active && event_link_controller_mode == CPW_FORCE_HIZ);
    oe_next      = ~cut_out_next; // see RL6, RL7, RL9, RL16
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_reg   <= CPW_IDLE;
      cnt_reg     <= '0;
      up_reg      <= 1'b1;
      buf_reg     <= '0;
      cmp_reg     <= '0;
      nrm_reg     <= `CPW_OUT_INACTIVE;
      ctr_reg     <= `CPW_OUT_INACTIVE;
      tog_reg     <= `CPW_OUT_INACTIVE;
      oe_reg      <= 1'b1;
      cut_out_reg <= 1'b0;
      cut_reg     <= '0;
      evl_reg     <= '0;
    end else begin
      state_reg   <= state_next;
      cnt_reg     <= cnt_next;
      up_reg      <= up_next;
      buf_reg     <= buf_next;
      cmp_reg     <= cmp_next;
      nrm_reg     <= nrm_next;
      ctr_reg     <= ctr_next;
      tog_reg     <= tog_next;
      oe_reg      <= oe_next;
      cut_out_reg <= cut_out_next;
      cut_reg     <= cut_next;
      evl_reg     <= evl_next;
    end
  end

  // all pins straight from flip-flops
  assign phase1_normal_out      = nrm_reg; // see RL3, RL12
  assign phase2_normal_out      = nrm_reg;
  assign phase3_normal_out      = nrm_reg;
  assign phase1_counter_out     = ctr_reg;
  assign phase2_counter_out     = ctr_reg;
  assign phase3_counter_out     = ctr_reg;
  assign half_period_toggle_out = tog_reg;
  assign phase1_normal_oe       = oe_reg;
  assign phase2_normal_oe       = oe_reg;
  assign phase3_normal_oe       = oe_reg;
  assign phase1_counter_oe      = oe_reg;
  assign phase2_counter_oe      = oe_reg;
  assign phase3_counter_oe      = oe_reg;
  assign half_period_toggle_oe  = oe_reg;
  assign cutoff_active          = cut_out_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence evl_hiz_held;
    (event_link_controller_req && event_link_controller_mode == CPW_FORCE_HIZ)[*3];
  endsequence

  // an idle cycle that stays idle and is not forced must leave every pin inactive high
  idle_outputs_high_a: assert property ( // see RL13
    state_reg == CPW_IDLE && !run_enable && !force_lvl |=> nrm_reg && ctr_reg && tog_reg)
    else $error("outputs not inactive high while idle");
  cmp_cutoff_enter_a: assert property ( // see RL6
    (cmp_rise[1] && cmp_channel_armed[1]) |=> !oe_reg && cutoff_active)
    else $error("armed comparator rise did not float the pins");
  cmp_release_a: assert property ( // see RL7
    (cmp_fall[1] && cmp_channel_armed[1] && !cut_reg[0] && !cmp_rise[0] && !evl_active)
      |=> oe_reg)
    else $error("comparator fall did not release high impedance");
  disarmed_never_cuts_a: assert property ( // see RL8
    !cmp_channel_armed[0] |=> !cut_reg[0])
    else $error("disarmed comparator channel caused cutoff");
  cmp_hold_off_a: assert property ( // see RL5
    !boundary |=> cmp_reg == $past(cmp_reg))
    else $error("compare changed away from period boundary");
  cmp_transfer_a: assert property ( // see RL14
    boundary |=> cmp_reg == $past(buf_reg))
    else $error("buffer not transferred at underflow");
  toggle_half_a: assert property ( // see RL4
    half_evt && run_enable && !force_lvl |=> tog_reg != $past(tog_reg))
    else $error("toggle pin did not invert at half period");
  complement_a: assert property ( // see RL2
    state_reg == CPW_RUN && $past(state_next) == CPW_RUN && !$past(force_lvl)
      |-> ctr_reg == ~nrm_reg)
    else $error("counter phase not complement of normal phase");
  evl_hiz_a: assert property ( // see RL10
    evl_hiz_held |=> !oe_reg)
    else $error("event-link request did not float pins after its latency");
  cnt_bound_a: assert property ( // see RL1
    cnt_reg <= CW'(HALF))
    else $error("carrier counter beyond half period");
endmodule

// ### verif/cpw_stage_model.sv
`timescale 1ns/100ps
// power stage and overcurrent comparators facing the seven generator pins
module cpw_stage_model (
  // clock
  input  wire logic       clk,
  // pin drive from the generator
  input  wire logic [6:0] pin_out,
  input  wire logic [6:0] pin_oe,
  // overcurrent level commanded by the bench
  input  wire logic [1:0] over_cmd,
  // comparator levels and resolved pin levels
  output logic [1:0]      comparator_hiz_request,
  output logic [6:0]      pin_level
);
  logic [6:0] last_reg;

  // a floated pin has no pull, so it shows the inverse of its last level
  always_ff @(posedge clk) last_reg <= pin_level;
  assign pin_level = (pin_oe & pin_out) | (~pin_oe & ~last_reg);
  // comparators are analog: their edges land off the clock edge
  assign #1.3 comparator_hiz_request = over_cmd;
endmodule

// ### verif/tb.sv
`timescale 1ns/100ps
module tb import cpw_pkg::*;;
  localparam int PER = 40;
  logic clk = 0, rstn = 0, run_enable = 0, duty_wr = 0, ev_req = 0;
  logic [15:0] duty_value = 16'h0000;
  logic [1:0]  armed = 2'b00, over_cmd = 2'b00, cmp_req;
  cpw_force_e  ev_mode = CPW_FORCE_HIZ;
  logic [6:0]  out_v, oe_v, pin_level;
  logic        cutoff_active;
  int          failures = 0, checked = 0, cycles = 0;

  cpw_top #(.PERIOD_CYC(PER)) i_cpw_top (
    .clk(clk), .rstn(rstn), .run_enable(run_enable), .duty_wr(duty_wr),
    .duty_value(duty_value), .comparator_hiz_request(cmp_req), .cmp_channel_armed(armed),
    .event_link_controller_req(ev_req), .event_link_controller_mode(ev_mode),
    .phase1_normal_out(out_v[0]), .phase1_normal_oe(oe_v[0]),
    .phase1_counter_out(out_v[1]), .phase1_counter_oe(oe_v[1]),
    .phase2_normal_out(out_v[2]), .phase2_normal_oe(oe_v[2]),
    .phase2_counter_out(out_v[3]), .phase2_counter_oe(oe_v[3]),
    .phase3_normal_out(out_v[4]), .phase3_normal_oe(oe_v[4]),
    .phase3_counter_out(out_v[5]), .phase3_counter_oe(oe_v[5]),
    .half_period_toggle_out(out_v[6]), .half_period_toggle_oe(oe_v[6]),
    .cutoff_active(cutoff_active));
  cpw_stage_model i_cpw_stage_model (.clk(clk), .pin_out(out_v), .pin_oe(oe_v),
    .over_cmd(over_cmd), .comparator_hiz_request(cmp_req), .pin_level(pin_level));

  // 250 MHz clock; the limit sits well above the roughly 460 cycles used
  always #2 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      failures++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("checks %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask
  // inputs move just after the edge, outputs are read there too
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // one carrier period: pairing, toggle spacing and count of active cycles
  task automatic watch_period(output int lo);
    int gap;
    logic prev;
    lo = 0;
    gap = -1;
    prev = out_v[6];
    repeat (PER) begin
      cyc(1);
      if (out_v[0] === 1'b0) lo++;
      check({out_v[2], out_v[4]}, {2{out_v[0]}}, "normal pins differ");
      check({out_v[3], out_v[5]}, {2{out_v[1]}}, "counter pins differ");
      check(out_v[1], {~out_v[0]}, "counter not inverse of normal");
      check(pin_level, out_v, "stage pin levels");
      if (out_v[6] !== prev) begin
        if (gap >= 0) check(16'(gap + 1), PER / 2, "toggle spacing");
        gap = 0;
      end else if (gap >= 0) gap++;
      prev = out_v[6];
    end
  endtask
  // new duty shows only from a boundary on; low count over a whole period
  task automatic test_duty(input logic [15:0] v, input int lo_min, input int lo_max);
    int lo;
    duty_value = v;
    duty_wr = 1;
    cyc(1);
    duty_wr = 0;
    cyc(2 * PER);
    watch_period(lo);
    check(lo >= lo_min && lo <= lo_max, 1, "active width");
  endtask
  task automatic wait_oe(input logic [6:0] exp);
    for (int k = 0; k < 8 && oe_v !== exp; k++) cyc(1);
  endtask
  task automatic test_cutoff();
    armed = 2'b11;
    over_cmd = 2'b10;
    wait_oe(7'h00);
    check(oe_v, 16'h0000, "pins not floated");
    check(cutoff_active, 16'h0001, "cutoff flag low");
    over_cmd = 2'b00;
    wait_oe(7'h7F);
    check(oe_v, 16'h007F, "pins not released");
    check(cutoff_active, 16'h0000, "cutoff flag stuck");
    armed = 2'b10;
    over_cmd = 2'b01;
    cyc(12);
    check(oe_v, 16'h007F, "disarmed channel cut");
    over_cmd = 2'b00;
    cyc(4);
  endtask
  task automatic test_event();
    cpw_force_e modes[3] = '{CPW_FORCE_HIZ, CPW_FORCE_HIGH, CPW_FORCE_LOW};
    foreach (modes[i]) begin
      ev_mode = modes[i];
      ev_req = 1;
      cyc(4);
      check(oe_v, (i == 0) ? 16'h0000 : 16'h007F, "event enable");
      check(cutoff_active, (i == 0) ? 16'h0001 : 16'h0000, "event cutoff flag");
      if (i > 0) check(out_v, (i == 1) ? 16'h007F : 16'h0000, "event level");
      ev_req = 0;
      cyc(4);
    end
  endtask

  initial begin
    int lo;
    cyc(4);
    check(out_v, 16'h007F, "reset levels");
    check(oe_v, 16'h007F, "reset enables");
    rstn = 1;
    armed = 2'b11;
    cyc(3);
    check(out_v, 16'h007F, "idle levels");
    run_enable = 1;
    test_duty(16'h0000, 0, 0);
    test_duty(16'h0015, PER, PER);
    test_duty(16'h0005, 9, 11);
    test_cutoff();
    watch_period(lo);
    test_event();
    run_enable = 0;
    cyc(3);
    check(out_v, 16'h007F, "stop levels");
    report_and_stop();
  end
endmodule
